//--- include/dss_pkg.sv
// package for the ddc channel sync-source select bank
// assumes a single 40 mhz clock domain and a 32-bit avalon-mm slave port
package dss_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and bus geometry
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 16;
    localparam int          IDX_W           = 6;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_TADJ_GAIN   = 6'h1c;
    localparam logic [5:0]  IDX_OSC         = 6'h1d;
    localparam logic [5:0]  IDX_CHECKSUM    = 6'h20;
    localparam logic [5:0]  IDX_ONESHOT     = 6'h3e;
    localparam logic [5:0]  IDX_PAGE        = 6'h3f;

    ////////////////////////////////////////////////////////////////////////
    // paging: page value is {4'h0, channel nibble, group byte}
    localparam logic [3:0]  PAGE_TOP        = 4'h0;
    localparam logic [7:0]  PAGE_GRP_SYNC   = 8'h00;
    localparam logic [7:0]  PAGE_GRP_CHK    = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // field positions inside both sync registers
    localparam int          SEL_W           = 3;
    localparam int          SEL_HI_LSB      = 12;
    localparam int          SEL_MH_LSB      = 8;
    localparam int          SEL_ML_LSB      = 4;
    localparam int          SEL_LO_LSB      = 0;
    localparam logic [15:0] SYNC_FIELD_MASK = 16'h7777;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] TADJ_GAIN_RST   = 16'h0000;
    localparam logic [15:0] OSC_RST         = 16'h0000;
    localparam logic [15:0] CHECKSUM_RST    = 16'h0000;
    localparam logic [15:0] PAGE_RST        = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // sync source codes
    localparam logic [2:0]  SSEL_EXT_A      = 3'h0;
    localparam logic [2:0]  SSEL_EXT_B      = 3'h1;
    localparam logic [2:0]  SSEL_EXT_C      = 3'h2;
    localparam logic [2:0]  SSEL_EXT_D      = 3'h3;
    localparam logic [2:0]  SSEL_COUNTER    = 3'h4;
    localparam logic [2:0]  SSEL_ONESHOT    = 3'h5;
    localparam logic [2:0]  SSEL_LOW        = 3'h6;
    localparam logic [2:0]  SSEL_HIGH       = 3'h7;

    typedef struct packed {
        logic ext_a;
        logic ext_b;
        logic ext_c;
        logic ext_d;
        logic counter;
        logic oneshot;
    } dss_sync_src_type;

    typedef struct packed {
        logic tadj_fine;
        logic tadj_reg;
        logic gain_load;
        logic agc_init;
        logic nco_reset;
        logic dither_reset;
        logic freq_load;
        logic phase_load;
    } dss_sync_out_type;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } dss_bus_state_type;

    function automatic logic dss_pick(input logic [2:0]       sel,
                                      input dss_sync_src_type src);
        logic r;
        case (sel)
            SSEL_EXT_A:   r = src.ext_a;
            SSEL_EXT_B:   r = src.ext_b;
            SSEL_EXT_C:   r = src.ext_c;
            SSEL_EXT_D:   r = src.ext_d;
            SSEL_COUNTER: r = src.counter;
            SSEL_ONESHOT: r = src.oneshot;
            SSEL_LOW:     r = 1'b0;
            SSEL_HIGH:    r = 1'b1;
            default:      r = 1'b0;
        endcase
        return r;
    endfunction

endpackage

//--- hw/dss_pin_sync.sv
// two-flop synchroniser for the external sync pins
// assumes the pins are asynchronous to CLK
module dss_pin_sync
    import dss_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [3:0] pin_in,
    output logic      [3:0] pin_sync
);

    logic [3:0] meta_reg;
    logic [3:0] meta_next;
    logic [3:0] sync_reg;
    logic [3:0] sync_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pin_sync = sync_reg;

endmodule

//--- hw/dss_sync_select.sv
// one registered sync-source multiplexer
// assumes sources are already in the CLK domain
module dss_sync_select
    import dss_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [2:0]       sel,
    input  wire dss_sync_src_type src,
    output logic                  sync_out
);

    logic sync_reg;
    logic sync_next;

    always_comb begin
        sync_next = dss_pick(sel, src);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule

//--- hw/dss_bank.sv
// ddc channel sync-source select bank with avalon-mm slave
// assumes one 40 mhz clock, synchronous reset, paged register access
//
// Overview of operation
// - bits 14:12 of index 0x1C pick the sync for fine time-adjust stuffing.
// - bits 10:8 of index 0x1C pick the sync that updates time-adjust values.
// - bits 6:4 of index 0x1C pick the sync that loads the agc gain value.
// - bits 2:0 of index 0x1C pick the sync that initialises the agc.
// - bits 14:12 of index 0x1D pick the sync that resets the nco phase acc.
// - bits 10:8 of index 0x1D pick the sync that resets the dither source.
// - bits 6:4 of index 0x1D pick the sync that loads a new nco frequency.
// - bits 2:0 of index 0x1D pick the sync that loads a new phase offset.
// - the 16-bit self-test checksum is readable in its own register.
// - the checksum register at index 0x20 is read-only, writes are dropped.
// - sync and checksum registers answer only on page 2*channel+1, groups 0x00 and 0x20.
// - codes 0-3 pick pins a-d, 4 counter, 5 one-shot, 6 low, 7 high.
module dss_bank
    import dss_pkg::*;
#(
    parameter logic [2:0] CHANNEL_INDEX = 3'h0
)
(
    input  wire logic              CLK,
    input  wire logic              SRST,
    input  wire logic [7:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output logic      [31:0]       AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    input  wire logic              EXTERNAL_SYNC_INPUT_A,
    input  wire logic              EXTERNAL_SYNC_INPUT_B,
    input  wire logic              EXTERNAL_SYNC_INPUT_C,
    input  wire logic              EXTERNAL_SYNC_INPUT_D,
    input  wire logic              SYNC_COUNTER_EVENT,
    input  wire logic [15:0]       SELFTEST_SUM,
    input  wire logic              SELFTEST_DONE,
    output dss_sync_out_type       SYNC_EVENTS
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic page_is(input logic [15:0] page,
                                     input logic [7:0]  grp);
        logic [3:0] nib;
        nib = {CHANNEL_INDEX, 1'b1};
        return page == {PAGE_TOP, nib, grp};
    endfunction

    // byte lanes 0 and 1 carry the 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    dss_bus_state_type state_reg;
    dss_bus_state_type state_next;
    logic              waitreq_reg;
    logic              waitreq_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic [15:0]       page_reg;
    logic [15:0]       page_next;
    logic [15:0]       tadj_gain_reg;
    logic [15:0]       tadj_gain_next;
    logic [15:0]       osc_reg;
    logic [15:0]       osc_next;
    logic [15:0]       checksum_reg;
    logic [15:0]       checksum_next;
    logic              oneshot_reg;
    logic              oneshot_next;

    logic [5:0]        idx;
    logic              req;
    logic              wr_take;
    logic              sync_page;
    logic              chk_page;
    logic [15:0]       rd_value;
    logic [3:0]        pins_sync;
    dss_sync_src_type  src;
    logic [7:0]        sync_vec;

    assign idx       = AVS_ADDRESS[7:2];
    assign req       = AVS_READ | AVS_WRITE;
    // write lands at the edge the master sees waitrequest low
    assign wr_take   = AVS_WRITE & (state_reg == BUS_ACK);
    assign sync_page = page_is(page_reg, PAGE_GRP_SYNC);
    assign chk_page  = page_is(page_reg, PAGE_GRP_CHK);

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then one cycle with waitrequest low

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BUS_IDLE: begin
                if (req) begin
                    state_next = BUS_ACK;
                end
            end
            BUS_ACK: begin
                state_next = BUS_IDLE;
            end
            default: begin
                state_next = BUS_IDLE;
            end
        endcase
        waitreq_next = (state_next != BUS_ACK);
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg   <= BUS_IDLE;
            waitreq_reg <= 1'b1;
        end else begin
            state_reg   <= state_next;
            waitreq_reg <= waitreq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped or off-page reads return zero

    always_comb begin
        rd_value = 16'h0000;
        if (idx == IDX_TADJ_GAIN && sync_page) begin
            rd_value = tadj_gain_reg & SYNC_FIELD_MASK;
        end else if (idx == IDX_OSC && sync_page) begin
            rd_value = osc_reg & SYNC_FIELD_MASK;
        end else if (idx == IDX_CHECKSUM && chk_page) begin
            rd_value = checksum_reg;
        end else if (idx == IDX_PAGE) begin
            rd_value = page_reg;
        end
        rdata_next = rdata_reg;
        if (AVS_READ && state_reg == BUS_IDLE) begin
            rdata_next = {16'h0000, rd_value};
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes

    always_comb begin
        page_next      = page_reg;
        tadj_gain_next = tadj_gain_reg;
        osc_next       = osc_reg;
        checksum_next  = checksum_reg;
        oneshot_next   = 1'b0;
        if (wr_take && idx == IDX_PAGE) begin
            page_next = merge(page_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        if (wr_take && idx == IDX_TADJ_GAIN && sync_page) begin
            // unused bits never stored
            tadj_gain_next = merge(tadj_gain_reg, AVS_WRITEDATA,
                                   AVS_BYTEENABLE) & SYNC_FIELD_MASK;
        end
        if (wr_take && idx == IDX_OSC && sync_page) begin
            osc_next = merge(osc_reg, AVS_WRITEDATA,
                             AVS_BYTEENABLE) & SYNC_FIELD_MASK;
        end
        // bus writes never reach the checksum
        if (SELFTEST_DONE) begin
            checksum_next = SELFTEST_SUM;
        end
        // any write to the trigger index fires the one-shot source
        if (wr_take && idx == IDX_ONESHOT) begin
            oneshot_next = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            page_reg      <= PAGE_RST;
            tadj_gain_reg <= TADJ_GAIN_RST;
            osc_reg       <= OSC_RST;
            checksum_reg  <= CHECKSUM_RST;
            oneshot_reg   <= 1'b0;
        end else begin
            page_reg      <= page_next;
            tadj_gain_reg <= tadj_gain_next;
            osc_reg       <= osc_next;
            checksum_reg  <= checksum_next;
            oneshot_reg   <= oneshot_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync sources and selection

    dss_pin_sync u_pin_sync (
        .clk      (CLK),
        .srst     (SRST),
        .pin_in   ({EXTERNAL_SYNC_INPUT_A, EXTERNAL_SYNC_INPUT_B,
                    EXTERNAL_SYNC_INPUT_C, EXTERNAL_SYNC_INPUT_D}),
        .pin_sync (pins_sync)
    );

    // counter event comes from on-chip logic, so no synchroniser
    assign src.ext_a   = pins_sync[3];
    assign src.ext_b   = pins_sync[2];
    assign src.ext_c   = pins_sync[1];
    assign src.ext_d   = pins_sync[0];
    assign src.counter = SYNC_COUNTER_EVENT;
    assign src.oneshot = oneshot_reg;

    // decode of each selector code
    dss_sync_select u_tadj_fine (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (tadj_gain_reg[SEL_HI_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[7])
    );

    dss_sync_select u_tadj_reg (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (tadj_gain_reg[SEL_MH_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[6])
    );

    dss_sync_select u_gain_load (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (tadj_gain_reg[SEL_ML_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[5])
    );

    dss_sync_select u_agc_init (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (tadj_gain_reg[SEL_LO_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[4])
    );

    dss_sync_select u_nco_reset (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (osc_reg[SEL_HI_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[3])
    );

    dss_sync_select u_dither_reset (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (osc_reg[SEL_MH_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[2])
    );

    dss_sync_select u_freq_load (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (osc_reg[SEL_ML_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[1])
    );

    dss_sync_select u_phase_load (
        .clk      (CLK),
        .srst     (SRST),
        .sel      (osc_reg[SEL_LO_LSB +: SEL_W]),
        .src      (src),
        .sync_out (sync_vec[0])
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = waitreq_reg;
    assign SYNC_EVENTS     = dss_sync_out_type'(sync_vec);

endmodule

//--- dv/dss_bank_sva.sv
// checker for the sync-source select bank
// sees only the bank's top ports; bound from the bench top
module dss_bank_sva
    import dss_pkg::*;
#(
    parameter logic [2:0] CHANNEL_INDEX = 3'h0
)
(
    input wire logic             CLK,
    input wire logic             SRST,
    input wire logic [7:0]       AVS_ADDRESS,
    input wire logic             AVS_READ,
    input wire logic             AVS_WRITE,
    input wire logic [31:0]      AVS_WRITEDATA,
    input wire logic [3:0]       AVS_BYTEENABLE,
    input wire logic [31:0]      AVS_READDATA,
    input wire logic             AVS_WAITREQUEST,
    input wire logic             SYNC_COUNTER_EVENT,
    input wire logic [15:0]      SELFTEST_SUM,
    input wire logic             SELFTEST_DONE,
    input wire dss_sync_out_type SYNC_EVENTS
);
    ////////////////////////////////////////////////////////////////////////
    // shadow of the register state, updated on accepted writes, checksum on SELFTEST_DONE
    logic [15:0] page_reg, tadj_reg, osc_reg, chk_reg;
    logic [15:0] page_next, tadj_next, osc_next, chk_next;
    logic [15:0] bm, wd;
    logic [5:0]  idx;
    logic        wr_acc, rd_acc, pg_sync, pg_chk;

    always_comb begin
        idx = AVS_ADDRESS[7:2];
        pg_sync = page_reg == {PAGE_TOP, CHANNEL_INDEX, 1'b1, PAGE_GRP_SYNC};
        pg_chk = page_reg == {PAGE_TOP, CHANNEL_INDEX, 1'b1, PAGE_GRP_CHK};
        wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
        rd_acc = AVS_READ && !AVS_WAITREQUEST;
        bm = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        wd = AVS_WRITEDATA[15:0];
        page_next = page_reg;
        tadj_next = tadj_reg;
        osc_next = osc_reg;
        chk_next = SELFTEST_DONE ? SELFTEST_SUM : chk_reg;
        if (wr_acc && idx == IDX_PAGE) begin
            page_next = (page_reg & ~bm) | (wd & bm);
        end
        if (wr_acc && pg_sync && idx == IDX_TADJ_GAIN) begin
            tadj_next = ((tadj_reg & ~bm) | (wd & bm)) & SYNC_FIELD_MASK;
        end
        if (wr_acc && pg_sync && idx == IDX_OSC) begin
            osc_next = ((osc_reg & ~bm) | (wd & bm)) & SYNC_FIELD_MASK;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            page_reg <= 16'h0000;
            tadj_reg <= 16'h0000;
            osc_reg  <= 16'h0000;
            chk_reg  <= 16'h0000;
        end else begin
            page_reg <= page_next;
            tadj_reg <= tadj_next;
            osc_reg  <= osc_next;
            chk_reg  <= chk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_rd_tadj;
        rd_acc && pg_sync && idx == IDX_TADJ_GAIN
            |-> AVS_READDATA == {16'h0000, tadj_reg};
    endproperty
    a_rd_tadj: assert property (p_rd_tadj)
        else $error("sync register one read mismatch");

    property p_rd_osc;
        rd_acc && pg_sync && idx == IDX_OSC
            |-> AVS_READDATA == {16'h0000, osc_reg};
    endproperty
    a_rd_osc: assert property (p_rd_osc)
        else $error("sync register two read mismatch");

    property p_rd_chk;
        rd_acc && pg_chk && idx == IDX_CHECKSUM
            |-> AVS_READDATA == {16'h0000, $past(chk_reg)};
    endproperty
    a_rd_chk: assert property (p_rd_chk)
        else $error("checksum read mismatch");

    property p_off_page;
        rd_acc && !pg_sync && (idx == IDX_TADJ_GAIN || idx == IDX_OSC)
            |-> AVS_READDATA == 32'h00000000;
    endproperty
    a_off_page: assert property (p_off_page)
        else $error("sync register visible off its page");

    property p_unused;
        rd_acc && (idx == IDX_TADJ_GAIN || idx == IDX_OSC)
            |-> (AVS_READDATA & 32'h00008888) == 32'h00000000;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused sync bit reads one");

    property p_low;
        tadj_reg[14:12] == SSEL_LOW |=> !SYNC_EVENTS.tadj_fine;
    endproperty
    a_low: assert property (p_low)
        else $error("constant low source not low");

    property p_high;
        osc_reg[14:12] == SSEL_HIGH |=> SYNC_EVENTS.nco_reset;
    endproperty
    a_high: assert property (p_high)
        else $error("constant high source not high");

    property p_cnt;
        tadj_reg[6:4] == SSEL_COUNTER
            |=> SYNC_EVENTS.gain_load == $past(SYNC_COUNTER_EVENT);
    endproperty
    a_cnt: assert property (p_cnt)
        else $error("counter source not followed");

    // one-shot: two cycles from the accepting edge, one cycle wide
    sequence s_os_req;
        wr_acc && idx == IDX_ONESHOT && osc_reg[2:0] == SSEL_ONESHOT;
    endsequence
    sequence s_os_pulse;
        ##1 !SYNC_EVENTS.phase_load ##1 SYNC_EVENTS.phase_load
            ##1 !SYNC_EVENTS.phase_load;
    endsequence
    property p_os;
        s_os_req |-> s_os_pulse;
    endproperty
    a_os: assert property (p_os)
        else $error("one-shot pulse wrong");
endmodule

//--- dv/dss_bank_tb_top.sv
// self-checking bench for the sync-source select bank
// drives every bank port itself; channel 2, so pages 0x0500 and 0x0520
module dss_bank_tb_top
    import dss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk, srst, rd, wr, sa, sb, sc, sd, cnt, done;
    logic [7:0]       addr;
    logic [31:0]      wdata, rdata, q;
    logic [3:0]       be;
    logic             waitreq;
    logic [15:0]      sum, v;
    dss_sync_out_type ev;
    int               n_fail, check_count;
    int               src_i [5] = '{0, 4, 3, 2, 1};
    logic [7:0]       exp_i [5] = '{8'h81, 8'h91, 8'h99, 8'h9d, 8'h9f};

    dss_bank #(.CHANNEL_INDEX(3'h2)) DUT (
        .CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .EXTERNAL_SYNC_INPUT_A(sa), .EXTERNAL_SYNC_INPUT_B(sb),
        .EXTERNAL_SYNC_INPUT_C(sc), .EXTERNAL_SYNC_INPUT_D(sd),
        .SYNC_COUNTER_EVENT(cnt), .SELFTEST_SUM(sum),
        .SELFTEST_DONE(done), .SYNC_EVENTS(ev));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_ev(input logic [7:0] e);
        check({24'h000000, ev}, {24'h000000, e});
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon cycle; an edge always passes before the request rises
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d, input logic [3:0] b);
        @(posedge clk);
        addr  <= a;
        wdata <= {16'h0000, d};
        be    <= b;
        wr    <= w;
        rd    <= !w;
        // no local limit: a hang is ended by the watchdog
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000, 4'hf);
        check(q, {16'h0000, e});
    endtask

    task automatic src(input int c, input logic x);
        @(posedge clk);
        case (c)
            0: sa <= x;
            1: sb <= x;
            2: sc <= x;
            3: sd <= x;
            4: cnt <= x;
            default: ;
        endcase
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {srst, rd, wr, sa, sb, sc, sd, cnt, done} = 9'h100;
        {addr, wdata, be, sum} = '0;
        n_fail = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd_chk(8'h70, 16'h0000);
        wr16(8'hfc, 16'h0500);
        rd_chk(8'h70, 16'h0000);
        rd_chk(8'h74, 16'h0000);
        wr16(8'h70, 16'hffff);
        rd_chk(8'h70, 16'h7777);
        wr16(8'h74, 16'hffff);
        bus(1'b1, 8'h74, 16'h0000, 4'h2);  // upper lane only
        rd_chk(8'h74, 16'h0077);
        wr16(8'hfc, 16'h0100);            // page of another channel
        wr16(8'h70, 16'h1234);
        rd_chk(8'h70, 16'h0000);
        wr16(8'hfc, 16'h0500);
        rd_chk(8'h70, 16'h7777);
        wr16(8'hfc, 16'h0520);
        rd_chk(8'h70, 16'h0000);
        rd_chk(8'h80, 16'h0000);
        @(posedge clk);
        sum  <= 16'hbeef;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        rd_chk(8'h80, 16'hbeef);
        wr16(8'h80, 16'h1111);
        rd_chk(8'h80, 16'hbeef);
        rd_chk(8'h40, 16'h0000);
        // distinct code in every field pins down the field positions
        wr16(8'hfc, 16'h0500);
        wr16(8'h70, 16'h7654);
        wr16(8'h74, 16'h3210);
        tick(5);
        chk_ev(8'h80);
        for (int i = 0; i < 5; i++) begin
            src(src_i[i], 1'b1);
            tick(5);
            chk_ev(exp_i[i]);
        end
        for (int i = 0; i < 5; i++) begin
            src(i, 1'b0);
        end
        // every code in every field at once
        for (int c = 0; c < 8; c++) begin
            v = {4{1'b0, c[2:0]}};
            wr16(8'h70, v);
            wr16(8'h74, v);
            if (c == 5) begin
                wr16(8'hf8, 16'h0000);
                tick(1);
                chk_ev(8'hff);
                tick(1);
                chk_ev(8'h00);
            end else begin
                tick(5);
                chk_ev((c == 7) ? 8'hff : 8'h00);
                src(c, 1'b1);
                tick(5);
                chk_ev((c == 6) ? 8'h00 : 8'hff);
                src(c, 1'b0);
            end
        end
        // mid-run reset must clear what the loop left behind
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        tick(2);
        chk_ev(8'h00);
        wr16(8'hfc, 16'h0500);
        rd_chk(8'h70, 16'h0000);
        rd_chk(8'h74, 16'h0000);
        wr16(8'hfc, 16'h0520);
        rd_chk(8'h80, 16'h0000);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule

bind dss_bank dss_bank_sva #(.CHANNEL_INDEX(CHANNEL_INDEX)) u_sva (
    .CLK                (CLK),
    .SRST               (SRST),
    .AVS_ADDRESS        (AVS_ADDRESS),
    .AVS_READ           (AVS_READ),
    .AVS_WRITE          (AVS_WRITE),
    .AVS_WRITEDATA      (AVS_WRITEDATA),
    .AVS_BYTEENABLE     (AVS_BYTEENABLE),
    .AVS_READDATA       (AVS_READDATA),
    .AVS_WAITREQUEST    (AVS_WAITREQUEST),
    .SYNC_COUNTER_EVENT (SYNC_COUNTER_EVENT),
    .SELFTEST_SUM       (SELFTEST_SUM),
    .SELFTEST_DONE      (SELFTEST_DONE),
    .SYNC_EVENTS        (SYNC_EVENTS)
);
